// ---- include/sfp_pkg.sv ----
// constants for the sequencer result and command queue register ports
// Functional notes
// - source select picks ADC, DFT, sinc2, variance or mean result for the data queue.
// - ADC source queues the calibrated sinc3 output word.
// - DFT real and imaginary parts are 18 bits, two lowest bits fractional.
// - a 30-bit variance result fills two consecutive data queue entries.
// - sinc2 and mean results enter the queue as 16-bit values.
// - enable low holds the data queue empty, pointers reset, no transfers.
// - CRC-8 over every executed command, read-only, resets to one.
// - live 30-bit timeout count readable, upper two bits zero.
// - reading the data port while empty returns zero.
// - writing the command port while full is discarded, stored commands unchanged.
// - ordinary word: ecc 31:25, sequence tag 24:23, channel 22:16, data 15:0.
// - DFT word: same ecc and tag, channel 11111 in 22:18, data 17:0.
package sfp_pkg;
  // register byte offsets
  localparam logic [15:0] SFP_OFF_CFG = 16'h2008;
  localparam logic [15:0] SFP_OFF_CRC = 16'h2060;
  localparam logic [15:0] SFP_OFF_TMO = 16'h2068;
  localparam logic [15:0] SFP_OFF_DQRD = 16'h206c;
  localparam logic [15:0] SFP_OFF_CQWR = 16'h2070;
  localparam logic [15:0] SFP_OFF_IRQ_STS = 16'h2074;
  localparam logic [15:0] SFP_OFF_IRQ_MSK = 16'h2078;
  // config fields and reset values
  localparam logic [15:0] SFP_CFG_RST = 16'h1010;
  localparam int SFP_SRC_LSB = 13;
  localparam int SFP_EN_BIT = 11;
  localparam logic [7:0] SFP_CRC_RST = 8'h01;
  localparam logic [7:0] SFP_CRC_POLY = 8'h07;
  // data source codes
  localparam logic [2:0] SFP_SRC_DFT = 3'h2;
  localparam logic [2:0] SFP_SRC_SINC2 = 3'h3;
  localparam logic [2:0] SFP_SRC_VAR = 3'h4;
  localparam logic [2:0] SFP_SRC_MEAN = 3'h5;
  // word layout
  localparam logic [4:0] SFP_DFT_CH = 5'h1f;
  // interrupt status bits
  localparam int SFP_IRQ_W = 3;
  localparam int SFP_IRQ_DQ_OVF = 0;
  localparam int SFP_IRQ_CQ_OVF = 1;
  localparam int SFP_IRQ_DQ_UNF = 2;
endpackage

// ---- hdl/sfp_top.sv ----
// data queue and command queue register ports of the sequencer
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sfp_top #(
  parameter int DQ_DEPTH = 16,
  parameter int CQ_DEPTH = 16
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement results
  input wire logic [1:0] meas_sequence_tag,
  input wire logic [6:0] meas_channel_tag,
  input wire logic adc_valid,
  input wire logic [15:0] adc_result,
  input wire logic dft_valid,
  input wire logic [17:0] dft_real,
  input wire logic [17:0] dft_imag,
  input wire logic sinc2_valid,
  input wire logic [15:0] sinc2_result,
  input wire logic var_valid,
  input wire logic [29:0] var_result,
  input wire logic mean_valid,
  input wire logic [15:0] mean_result,
  // sequencer side
  input wire logic cmd_pop,
  output logic cmd_valid,
  output logic [31:0] cmd_word,
  input wire logic seq_exec_valid,
  input wire logic [31:0] seq_exec_word,
  input wire logic [29:0] seq_timeout_count,
  // interrupt
  output logic irq
);
  import sfp_pkg::*;
  localparam int DAW = $clog2(DQ_DEPTH);
  localparam int CAW = $clog2(CQ_DEPTH);
  // ecc bit i is parity of payload bits whose index mod 7 is i
  function automatic logic [6:0] ecc7(input logic [24:0] p);
    logic [6:0] e;
    e = 7'h00;
    for (int j = 0; j < 25; j++) begin
      e[j % 7] = e[j % 7] ^ p[j];
    end
    return e;
  endfunction
  function automatic logic [31:0] mkword(input logic [1:0] t, input logic [6:0] c,
                                         input logic [15:0] d);
    return {ecc7({t, c, d}), t, c, d};
  endfunction
  function automatic logic [31:0] mkdft(input logic [1:0] t, input logic [17:0] d);
    return {ecc7({t, SFP_DFT_CH, d}), t, SFP_DFT_CH, d};
  endfunction
  // msb first crc over one command word
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [31:0] w);
    logic [7:0] r;
    r = c;
    for (int j = 31; j >= 0; j--) begin
      r = (r[7] ^ w[j]) ? {r[6:0], 1'b0} ^ SFP_CRC_POLY : {r[6:0], 1'b0};
    end
    return r;
  endfunction
  // register state
  logic [15:0] cfg_q, cfg_d;
  logic [7:0] crc_q, crc_d;
  logic [SFP_IRQ_W-1:0] sts_q, sts_d, msk_q, msk_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  // data queue state
  logic [31:0] dq_mem [DQ_DEPTH];
  logic [DAW-1:0] dq_wp_q, dq_wp_d, dq_rp_q, dq_rp_d;
  logic [DAW:0] dq_cnt_q, dq_cnt_d;
  logic pend_q, pend_d;
  logic [31:0] pend_w_q, pend_w_d;
  // command queue state
  logic [31:0] cq_mem [CQ_DEPTH];
  logic [CAW-1:0] cq_wp_q, cq_wp_d, cq_rp_q, cq_rp_d;
  logic [CAW:0] cq_cnt_q, cq_cnt_d;
  logic [31:0] cmd_word_q, cmd_word_d;
  logic cmd_valid_q, cmd_valid_d;
  // working signals
  logic [2:0] src;
  logic en, new_v, sec_v, push_v, lost, dq_full, dq_wr, dq_rd, cq_full, cq_wr, cq_rd;
  logic [31:0] new_w, sec_w, push_w;
  logic capture, done, hit_dq, hit_cq, mapped;

  // bus decode: capture one cycle into access, finish on the next
  always_comb begin
    capture = psel & penable & ~pready_q;
    done = psel & penable & pready_q;
    hit_dq = paddr == SFP_OFF_DQRD;
    hit_cq = paddr == SFP_OFF_CQWR;
    mapped = (paddr == SFP_OFF_CFG) | (paddr == SFP_OFF_CRC) | (paddr == SFP_OFF_TMO) |
             hit_dq | hit_cq | (paddr == SFP_OFF_IRQ_STS) | (paddr == SFP_OFF_IRQ_MSK);
  end

  // source routing and word building
  always_comb begin
    src = cfg_q[SFP_SRC_LSB +: 3];
    en = cfg_q[SFP_EN_BIT];
    sec_v = 1'b0;
    sec_w = 32'h0000_0000;
    case (src)
      SFP_SRC_DFT: begin
        new_v = dft_valid;
        new_w = mkdft(meas_sequence_tag, dft_real);
        sec_v = dft_valid;
        sec_w = mkdft(meas_sequence_tag, dft_imag);
      end
      SFP_SRC_SINC2: begin
        new_v = sinc2_valid;
        new_w = mkword(meas_sequence_tag, meas_channel_tag, sinc2_result);
      end
      SFP_SRC_VAR: begin // low half first, high half next
        new_v = var_valid;
        new_w = mkword(meas_sequence_tag, meas_channel_tag, var_result[15:0]);
        sec_v = var_valid;
        sec_w = mkword(meas_sequence_tag, meas_channel_tag, {2'b00, var_result[29:16]});
      end
      SFP_SRC_MEAN: begin
        new_v = mean_valid;
        new_w = mkword(meas_sequence_tag, meas_channel_tag, mean_result);
      end
      default: begin
        new_v = adc_valid;
        new_w = mkword(meas_sequence_tag, meas_channel_tag, adc_result);
      end
    endcase
  end

  // data queue next state; a second word blocks new samples for one cycle
  always_comb begin
    lost = pend_q & new_v;
    if (pend_q) begin
      push_v = 1'b1;
      push_w = pend_w_q;
      pend_d = 1'b0;
      pend_w_d = pend_w_q;
    end else begin
      push_v = new_v;
      push_w = new_w;
      pend_d = sec_v;
      pend_w_d = sec_w;
    end
    dq_full = dq_cnt_q == (DAW+1)'(DQ_DEPTH);
    dq_wr = en & push_v & ~dq_full;
    // pop at the capture edge, so the word shown is always the word removed
    dq_rd = en & capture & ~pwrite & hit_dq & (dq_cnt_q != '0);
    dq_wp_d = dq_wr ? dq_wp_q + 1'b1 : dq_wp_q;
    dq_rp_d = dq_rd ? dq_rp_q + 1'b1 : dq_rp_q;
    dq_cnt_d = dq_cnt_q + (DAW+1)'(dq_wr) - (DAW+1)'(dq_rd);
    if (!en) begin
      pend_d = 1'b0;
      dq_wp_d = '0;
      dq_rp_d = '0;
      dq_cnt_d = '0;
    end
  end
  // data queue pointers and pending second word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_wp_q <= '0;
      dq_rp_q <= '0;
      dq_cnt_q <= '0;
      pend_q <= 1'b0;
      pend_w_q <= 32'h0000_0000;
    end else begin
      dq_wp_q <= dq_wp_d;
      dq_rp_q <= dq_rp_d;
      dq_cnt_q <= dq_cnt_d;
      pend_q <= pend_d;
      pend_w_q <= pend_w_d;
    end
  end

  // storage array has no reset, only entries below the count are read
  always_ff @(posedge pclk) begin
    if (dq_wr) dq_mem[dq_wp_q] <= push_w;
    if (cq_wr) cq_mem[cq_wp_q] <= pwdata;
  end

  // command queue next state
  always_comb begin
    cq_full = cq_cnt_q == (CAW+1)'(CQ_DEPTH);
    cq_wr = done & pwrite & hit_cq & ~cq_full;
    cq_rd = cmd_pop & (cq_cnt_q != '0);
    cq_wp_d = cq_wr ? cq_wp_q + 1'b1 : cq_wp_q;
    cq_rp_d = cq_rd ? cq_rp_q + 1'b1 : cq_rp_q;
    cq_cnt_d = cq_cnt_q + (CAW+1)'(cq_wr) - (CAW+1)'(cq_rd);
    cmd_valid_d = cq_rd;
    cmd_word_d = cq_rd ? cq_mem[cq_rp_q] : cmd_word_q;
  end
  // command queue pointers and sequencer output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cq_wp_q <= '0;
      cq_rp_q <= '0;
      cq_cnt_q <= '0;
      cmd_valid_q <= 1'b0;
      cmd_word_q <= 32'h0000_0000;
    end else begin
      cq_wp_q <= cq_wp_d;
      cq_rp_q <= cq_rp_d;
      cq_cnt_q <= cq_cnt_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_word_q <= cmd_word_d;
    end
  end

  // registers, read mux and interrupt; events win over a clear in the same cycle
  always_comb begin
    cfg_d = cfg_q;
    msk_d = msk_q;
    sts_d = sts_q;
    crc_d = seq_exec_valid ? crc8(crc_q, seq_exec_word) : crc_q;
    pready_d = capture;
    pslverr_d = capture & ~mapped;
    prdata_d = prdata_q;
    if (capture) begin
      case (paddr)
        SFP_OFF_CFG: prdata_d = {16'h0000, cfg_q};
        SFP_OFF_CRC: prdata_d = {24'h00_0000, crc_q};
        SFP_OFF_TMO: prdata_d = {2'b00, seq_timeout_count};
        SFP_OFF_DQRD: begin
          prdata_d = (en && dq_cnt_q != '0) ? dq_mem[dq_rp_q] : 32'h0000_0000;
        end
        SFP_OFF_IRQ_STS: prdata_d = {{(32-SFP_IRQ_W){1'b0}}, sts_q};
        SFP_OFF_IRQ_MSK: prdata_d = {{(32-SFP_IRQ_W){1'b0}}, msk_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (done && pwrite) begin
      case (paddr)
        SFP_OFF_CFG: cfg_d = pwdata[15:0];
        SFP_OFF_IRQ_MSK: msk_d = pwdata[SFP_IRQ_W-1:0];
        SFP_OFF_IRQ_STS: sts_d = sts_q & ~pwdata[SFP_IRQ_W-1:0];
        default: cfg_d = cfg_q;
      endcase
    end
    sts_d[SFP_IRQ_DQ_OVF] = sts_d[SFP_IRQ_DQ_OVF] | (en & push_v & dq_full) | (en & lost);
    sts_d[SFP_IRQ_CQ_OVF] = sts_d[SFP_IRQ_CQ_OVF] | (done & pwrite & hit_cq & cq_full);
    sts_d[SFP_IRQ_DQ_UNF] = sts_d[SFP_IRQ_DQ_UNF] | (capture & ~pwrite & hit_dq & ~dq_rd);
    irq_d = |(sts_d & msk_d);
  end
  // register file, bus response and interrupt flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= SFP_CFG_RST;
      crc_q <= SFP_CRC_RST;
      msk_q <= '0;
      sts_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      crc_q <= crc_d;
      msk_q <= msk_d;
      sts_q <= sts_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end
  // every output straight from its flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_word = cmd_word_q;
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_src_sinc2;
    dq_wr && !pend_q && src == SFP_SRC_SINC2 |-> push_w[15:0] == sinc2_result;
  endproperty
  a_src_sinc2: assert property (p_src_sinc2) else $error("sinc2 data misrouted");
  property p_adc_route;
    dq_wr && !pend_q && (src == 3'h0 || src == 3'h7) |-> push_w[15:0] == adc_result;
  endproperty
  a_adc_route: assert property (p_adc_route) else $error("adc data misrouted");
  property p_var_two;
    en && !pend_q && src == SFP_SRC_VAR && var_valid |=> pend_q ##1 !pend_q;
  endproperty
  a_var_two: assert property (p_var_two) else $error("variance not split");
  property p_disabled;
    !en |=> dq_cnt_q == '0 && dq_wp_q == '0 && dq_rp_q == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("queue not held empty");
  property p_crc_hold;
    !seq_exec_valid |=> crc_q == $past(crc_q);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc moved without command");
  property p_tmo_read;
    capture && paddr == SFP_OFF_TMO |=> prdata_q == {2'b00, $past(seq_timeout_count)};
  endproperty
  a_tmo_read: assert property (p_tmo_read) else $error("timeout read wrong");
  property p_empty_zero;
    capture && hit_dq && dq_cnt_q == '0 |=> pready_q && prdata_q == 32'h0000_0000;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty read not zero");
  property p_full_drop;
    done && pwrite && hit_cq && cq_full && !cmd_pop |=> cq_cnt_q == $past(cq_cnt_q);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full write accepted");
  property p_ecc;
    dq_wr |-> push_w[31:25] == ecc7(push_w[24:0]);
  endproperty
  a_ecc: assert property (p_ecc) else $error("bad ecc field");
  // a pending second word of another source may land just after a switch to dft
  property p_dft_tag;
    dq_wr && src == SFP_SRC_DFT && $past(src) == SFP_SRC_DFT |-> push_w[22:18] == SFP_DFT_CH;
  endproperty
  a_dft_tag: assert property (p_dft_tag) else $error("dft channel tag wrong");
  property p_pop;
    dq_rd && !dq_wr |=> dq_cnt_q == $past(dq_cnt_q) - 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not pop");
  property p_push;
    cq_wr && !cq_rd |=> cq_cnt_q == $past(cq_cnt_q) + 1'b1;
  endproperty
  a_push: assert property (p_push) else $error("write did not append");
  c_dq_pop: cover property (dq_rd);
  c_cq_full_write: cover property (done && pwrite && hit_cq && cq_full);
  c_dft_pair: cover property (en && src == SFP_SRC_DFT && dft_valid ##1 pend_q ##1 dq_wr);
  c_irq: cover property ($rose(irq_q));
endmodule
`default_nettype wire

// ---- test/sfp_host_model.sv ----
// apb host model: master side of the register port
`timescale 1ns/1ns
`default_nettype none
module sfp_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int hangs = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
  end
  // one transfer; caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // no fixed latency assumed: wait for pready, bounded
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hangs++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- test/sequencer_fifo_ports_bench.sv ----
// self-checking bench for the result and command queue ports
`timescale 1ns/1ns
`default_nettype none
module sequencer_fifo_ports_bench;
  import sfp_pkg::*;
  localparam logic [1:0] TG = 2'h2;
  localparam logic [6:0] CH = 7'h15;
  localparam logic [17:0] DRE = 18'h2abcd;
  localparam logic [17:0] DIM = 18'h15432;
  localparam logic [29:0] VR = 30'h23456789;
  localparam logic [29:0] TMO = 30'h3abcd123;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, cmd_valid;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, cmd_word, r, e0, e1;
  logic adc_valid = 1'b0, dft_valid = 1'b0, sinc2_valid = 1'b0;
  logic var_valid = 1'b0, mean_valid = 1'b0, cmd_pop = 1'b0, seq_exec_valid = 1'b0;
  logic [31:0] seq_exec_word = 32'h0;
  logic [29:0] tmo_cnt = TMO;
  logic [7:0] crc;
  logic err;
  int fails = 0;
  int total_checks = 0;
  int n;
  always #5 pclk = ~pclk;
  sfp_host_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  sfp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_sequence_tag(TG), .meas_channel_tag(CH),
    .adc_valid(adc_valid), .adc_result(16'h1234), .dft_valid(dft_valid), .dft_real(DRE),
    .dft_imag(DIM), .sinc2_valid(sinc2_valid), .sinc2_result(16'h5a5a),
    .var_valid(var_valid), .var_result(VR), .mean_valid(mean_valid),
    .mean_result(16'h0f0f), .cmd_pop(cmd_pop), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .seq_exec_valid(seq_exec_valid), .seq_exec_word(seq_exec_word),
    .seq_timeout_count(tmo_cnt), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, err);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp, input string what);
    host.xfer(1'b0, a, 32'h0, r, err);
    chk(r, exp, what);
  endtask
  // queue word with check code; bit i folds payload bits of index mod 7
  function automatic logic [31:0] mk(input logic [24:0] p);
    logic [6:0] e;
    e = 7'h0;
    for (int i = 0; i < 25; i++) e[i % 7] ^= p[i];
    return {e, p};
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [31:0] w);
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // every source strobes at once, so only the selected one may land
  task automatic pulse();
    {adc_valid, dft_valid, sinc2_valid, var_valid, mean_valid} <= 5'h1f;
    @(posedge pclk);
    {adc_valid, dft_valid, sinc2_valid, var_valid, mean_valid} <= 5'h00;
    repeat (2) @(posedge pclk);
  endtask
  task automatic print_verdict();
    fails += host.hangs;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #300000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, read-only fields, unmapped address
    rchk(SFP_OFF_CFG, 32'h1010, "cfg");
    rchk(SFP_OFF_CRC, 32'h1, "crc");
    wr(SFP_OFF_CRC, 32'hff);
    rchk(SFP_OFF_CRC, 32'h1, "crc ro");
    rchk(SFP_OFF_TMO, {2'b00, TMO}, "timeout");
    tmo_cnt <= 30'h5a5a;
    rchk(SFP_OFF_TMO, 32'h0000_5a5a, "timeout live");
    rchk(16'h2100, 32'h0, "unmapped");
    chk({31'h0, err}, 32'h1, "pslverr");
    // queue held in reset while disabled; empty read gives zero
    pulse();
    rchk(SFP_OFF_DQRD, 32'h0, "dq off");
    chk({31'h0, irq}, 32'h0, "irq masked");
    rchk(SFP_OFF_IRQ_STS, 32'h4, "sts");
    wr(SFP_OFF_IRQ_MSK, 32'h7);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq");
    wr(SFP_OFF_IRQ_STS, 32'h4);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq clr");
    // every source code, word layout and pop order
    for (int c = 0; c < 8; c++) begin
      wr(SFP_OFF_CFG, {16'h0, 3'(c), 13'h1800});
      pulse();
      n = 1;
      case (c)
        2: begin
          e0 = mk({TG, SFP_DFT_CH, DRE});
          e1 = mk({TG, SFP_DFT_CH, DIM});
          n = 2;
        end
        3: e0 = mk({TG, CH, 16'h5a5a});
        4: begin
          e0 = mk({TG, CH, VR[15:0]});
          e1 = mk({TG, CH, 2'b00, VR[29:16]});
          n = 2;
        end
        5: e0 = mk({TG, CH, 16'h0f0f});
        default: e0 = mk({TG, CH, 16'h1234});
      endcase
      rchk(SFP_OFF_DQRD, e0, "dq w0");
      if (n == 2) rchk(SFP_OFF_DQRD, e1, "dq w1");
      rchk(SFP_OFF_DQRD, 32'h0, "dq empty");
    end
    rchk(SFP_OFF_CFG, 32'hf800, "cfg rw");
    // disabling empties the queue and blocks new samples
    wr(SFP_OFF_CFG, 32'h1800);
    pulse();
    wr(SFP_OFF_CFG, 32'h1000);
    pulse();
    wr(SFP_OFF_CFG, 32'h1800);
    rchk(SFP_OFF_DQRD, 32'h0, "dq flushed");
    // fill command queue past full, then drain in order
    for (int i = 0; i < 17; i++) wr(SFP_OFF_CQWR, 32'hc0de0000 + i);
    host.xfer(1'b0, SFP_OFF_IRQ_STS, 32'h0, r, err);
    chk(r & 32'h2, 32'h2, "cq full sts");
    for (int i = 0; i < 17; i++) begin
      cmd_pop <= 1'b1;
      @(posedge pclk);
      cmd_pop <= 1'b0;
      @(posedge pclk);
      chk({31'h0, cmd_valid}, {31'h0, i < 16}, "cmd_valid");
      if (i < 16) chk(cmd_word, 32'hc0de0000 + i, "cmd_word");
    end
    // checksum over executed commands
    crc = 8'h01;
    for (int i = 0; i < 3; i++) begin
      seq_exec_word <= 32'h5a3c0000 ^ i;
      seq_exec_valid <= 1'b1;
      @(posedge pclk);
      crc = crc8(crc, 32'h5a3c0000 ^ i);
    end
    seq_exec_valid <= 1'b0;
    @(posedge pclk);
    rchk(SFP_OFF_CRC, {24'h0, crc}, "crc acc");
    print_verdict();
  end
endmodule
`default_nettype wire
